// ==== bench/gwt_master.sv ====
// Purpose: bus master model issuing single-item requests
// Assumes: each request is answered by one ack pulse
// Notes: released lines carry inverted data so stale values never match
module gwt_master (
  input wire logic mclk,
  input wire logic ack,
  input wire logic [7:0] exc,
  input wire logic [15:0] rdata,
  output logic req,
  output logic [7:0] func,
  output logic [15:0] addr,
  output logic [15:0] wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req = 1'b0;
    func = 8'h00;
    addr = 16'h0000;
    wdata = 16'h0000;
  end
  // ==================================================================
  // one request, held until the answer is seen or eight cycles pass
  task automatic xfer(input logic [7:0] f, input logic [15:0] a,
      input logic [15:0] d, output logic [7:0] e, output logic [15:0] r);
    int n;
    logic ok;
    n = 0;
    @(negedge mclk);
    req <= 1'b1;
    func <= f;
    addr <= a;
    wdata <= d;
    do begin
      @(negedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 8);
    ok = (ack === 1'b1);
    // hold the request over the edge at which ack is sampled high
    @(posedge mclk);
    e = ok ? exc : 8'hff;
    r = rdata;
    @(negedge mclk);
    req <= 1'b0;
    func <= ~f;
    addr <= ~a;
    wdata <= ~d;
  endtask
endmodule

// ==== bench/tb_top.sv ====
// Purpose: self-checking bench of the warning flag bank
// Assumes: thresholds in ppm, flags in bit 0 of coil and input reads
// Notes: gas samples mix fixed boundary values with seeded random ones
`include "gwt_map.svh"
module tb_top
  import gwt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic gas_valid = 1'b0;
  logic sensor_fault_pin = 1'b0;
  logic year_elapsed = 1'b0;
  logic [15:0] gas_ppm = 16'h0000;
  logic [15:0] sw_alarm_ppm = 16'h01f4;
  logic [15:0] pot_alarm_ppm = 16'h0320;
  logic req, ack, relay_drive, sounder_on, red_lamp, green_lamp;
  logic warn_hit, nv_save, al, ht, xr;
  logic [7:0] func, exc, e;
  logic [15:0] addr, wdata, rdata, nv_value, r, g;
  logic [15:0] cor [4] = '{16'h012b, 16'h012c, 16'h01f3, 16'h01f4};
  int bad_count = 0;
  int cmp_count = 0;
  int saves = 0;
  int seed = 51;
  always #4 mclk = ~mclk;
  always @(posedge mclk) if (nv_save === 1'b1) saves++;
  gwt_master u_mst (.mclk(mclk), .ack(ack), .exc(exc), .rdata(rdata),
    .req(req), .func(func), .addr(addr), .wdata(wdata));
  gwt_core u_dut (.mclk(mclk), .rst(rst), .req(req), .func(func),
    .addr(addr), .wdata(wdata), .ack(ack), .exc(exc), .rdata(rdata),
    .gas_valid(gas_valid), .gas_ppm(gas_ppm), .sw_alarm_ppm(sw_alarm_ppm),
    .pot_alarm_ppm(pot_alarm_ppm), .sensor_fault_pin(sensor_fault_pin),
    .year_elapsed(year_elapsed), .relay_drive(relay_drive),
    .sounder_on(sounder_on), .red_lamp(red_lamp), .green_lamp(green_lamp),
    .warn_hit(warn_hit), .nv_save(nv_save), .nv_value(nv_value));
  // ==================================================================
  // checking helpers
  task automatic chk(input string w, input logic [15:0] s, x);
    cmp_count++;
    if (s !== x) begin
      bad_count++;
      $display("Error %s expected %h seen %h", w, x, s);
    end
  endtask
  task automatic acc(input logic [7:0] f, input logic [15:0] a, d, x,
      input logic [7:0] xe);
    u_mst.xfer(f, a, d, e, r);
    chk("exc", {8'h00, e}, {8'h00, xe});
    if (xe == 8'h00) chk("rdata", (f < 8'h03) ? {15'h0, r[0]} : r, x);
  endtask
  task automatic rc(input logic [15:0] a, x);
    acc(`GWT_FC_RD_COIL, a, 16'h0000, x, 8'h00);
  endtask
  task automatic ri(input logic [15:0] a, x);
    acc(`GWT_FC_RD_INPUT, a, 16'h0000, x, 8'h00);
  endtask
  task automatic wc(input logic [15:0] a, d, input logic [7:0] xe);
    acc(`GWT_FC_WR_COIL, a, d, d, xe);
  endtask
  task automatic sp(input logic [15:0] d, x, input logic [7:0] xe);
    acc(xe == 8'hff ? `GWT_FC_RD_HOLD : `GWT_FC_WR_HOLD, `GWT_A_WARN_SP,
      d, x, xe == 8'hff ? 8'h00 : xe);
  endtask
  // one sample; relay settles one edge after it is taken
  task automatic smp(input logic [15:0] v);
    @(negedge mclk);
    gas_valid <= 1'b1;
    gas_ppm <= v;
    @(negedge mclk);
    gas_valid <= 1'b0;
    gas_ppm <= ~v;
    @(negedge mclk);
  endtask
  function automatic logic exp_relay(logic a, f, h, w, s);
    return (a | f | (h & w)) ^ s;
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end
  // ==================================================================
  // main sequence
  initial begin
    repeat (12) @(posedge mclk);
    @(negedge mclk) rst = 1'b0;
    chk("green", green_lamp, 16'h1);
    chk("relay", relay_drive, 16'h0);
    rc(`GWT_A_FAILSAFE, 16'h0);
    rc(`GWT_A_WARN_EN, 16'h0);
    rc(`GWT_A_W2R, 16'h0);
    rc(`GWT_A_TEST, 16'h0);
    sp(16'h0, 16'h0, 8'hff);
    $display("done reset values");
    wc(`GWT_A_ALARM, `GWT_COIL_ON, `GWT_EX_ADDR);
    wc(`GWT_A_WARN_EN, 16'h1234, `GWT_EX_VALUE);
    acc(8'h07, `GWT_A_WARN_EN, 16'h0, 16'h0, `GWT_EX_FUNC);
    wc(`GWT_A_WARN_EN, `GWT_COIL_ON, 8'h00);
    rc(`GWT_A_WARN_EN, 16'h1);
    sp(16'd300, 16'd300, 8'h00);
    chk("nv_value", nv_value, 16'd300);
    sp(16'd501, 16'h0, `GWT_EX_VALUE);
    sp(16'h0, 16'd300, 8'hff);
    acc(`GWT_FC_WR_HOLD, `GWT_A_ALARM, 16'h0, 16'h0, `GWT_EX_ADDR);
    acc(`GWT_FC_RD_INPUT, `GWT_A_SOUNDER, 16'h0, 16'h0,
      `GWT_EX_ADDR);
    ri(`GWT_A_SPARE_A, 16'h0);
    $display("done access");
    for (int k = 0; k < 4; k++) begin
      wc(`GWT_A_FAILSAFE, k[0] ? `GWT_COIL_ON : 16'h0, 8'h00);
      wc(`GWT_A_W2R, k[1] ? `GWT_COIL_ON : 16'h0, 8'h00);
      for (int j = 0; j < 6; j++) begin
        g = j < 4 ? cor[j] : 16'($random(seed)) & 16'h03ff;
        smp(g);
        al = g >= 16'd500;
        ht = g >= 16'd300;
        xr = exp_relay(al, 1'b0, ht, k[1], k[0]);
        chk("warn_hit", warn_hit, ht);
        chk("relay", relay_drive, xr);
        chk("red", red_lamp, al);
        ri(`GWT_A_ALARM, al);
        ri(`GWT_A_RELAY, xr);
        ri(`GWT_A_WARN_HIT, ht);
      end
    end
    $display("done relay matrix");
    saves = 0;
    @(negedge mclk) sw_alarm_ppm = 16'd200;
    sp(16'h0, 16'd200, 8'hff);
    chk("nv_value", nv_value, 16'd200);
    chk("nv_save", 16'(saves > 0), 16'h1);
    @(negedge mclk) sw_alarm_ppm = 16'd600;
    sp(16'h0, 16'd200, 8'hff);
    @(negedge mclk) sw_alarm_ppm = 16'h0;
    smp(16'd700);
    ri(`GWT_A_ALARM, 16'h0);
    wc(`GWT_A_SOUNDER, 16'h0, 8'h00);
    chk("sounder", sounder_on, 16'h0);
    smp(16'd800);
    ri(`GWT_A_ALARM, 16'h1);
    chk("sounder", sounder_on, 16'h1);
    rc(`GWT_A_SOUNDER, 16'h1);
    wc(`GWT_A_WARN_EN, 16'h0, 8'h00);
    sp(16'h0, 16'h0, 8'hff);
    chk("nv_value", nv_value, 16'h0);
    smp(16'd900);
    chk("warn_hit", warn_hit, 16'h0);
    $display("done thresholds");
    smp(16'd100);
    @(negedge mclk) sensor_fault_pin = 1'b1;
    repeat (4) @(negedge mclk);
    ri(`GWT_A_FAULT, 16'h1);
    chk("green", green_lamp, 16'h0);
    chk("red", red_lamp, 16'h1);
    xr = exp_relay(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    chk("relay", relay_drive, xr);
    ri(`GWT_A_GREEN, 16'h0);
    @(negedge mclk) sensor_fault_pin = 1'b0;
    repeat (4) @(negedge mclk);
    ri(`GWT_A_FAULT, 16'h0);
    @(negedge mclk) year_elapsed = 1'b1;
    @(negedge mclk) year_elapsed = 1'b0;
    rc(`GWT_A_TEST, 16'h1);
    wc(`GWT_A_TEST, 16'h0, 8'h00);
    rc(`GWT_A_TEST, 16'h0);
    $display("done status flags");
    stop_test();
  end
endmodule

// ==== shared/gwt_map.svh ====
// Purpose: addresses, codes and reset values of the warning flag bank
// Assumes: 16-bit register numbers as carried in a modbus request
// Notes: definitions only
`ifndef GWT_MAP_SVH
`define GWT_MAP_SVH
// ====================================================================
// register numbers
`define GWT_A_WARN_SP 16'h00cb
`define GWT_A_ALARM 16'h012c
`define GWT_A_RELAY 16'h012d
`define GWT_A_FAULT 16'h012e
`define GWT_A_RED 16'h012f
`define GWT_A_GREEN 16'h0130
`define GWT_A_SPARE_A 16'h0131
`define GWT_A_SPARE_B 16'h0132
`define GWT_A_WARN_HIT 16'h0133
`define GWT_A_SOUNDER 16'h0190
`define GWT_A_TEST 16'h0191
`define GWT_A_FAILSAFE 16'h0192
`define GWT_A_WARN_EN 16'h0193
`define GWT_A_W2R 16'h0194
// ====================================================================
// function codes, coil values, exception codes
`define GWT_FC_RD_COIL 8'h01
`define GWT_FC_RD_INPUT 8'h02
`define GWT_FC_RD_HOLD 8'h03
`define GWT_FC_WR_COIL 8'h05
`define GWT_FC_WR_HOLD 8'h06
`define GWT_COIL_ON 16'hff00
`define GWT_COIL_OFF 16'h0000
`define GWT_EX_NONE 8'h00
`define GWT_EX_FUNC 8'h01
`define GWT_EX_ADDR 8'h02
`define GWT_EX_VALUE 8'h03
// ====================================================================
// reset values
`define GWT_RST_WARN_SP 16'h0000
`define GWT_RST_FLAG 1'b0
`endif

// ==== shared/gwt_pkg.sv ====
// Purpose: types of the warning flag bank
// Assumes: nothing beyond the map header
// Notes: state of the core travels as one packed struct
package gwt_pkg;
  // ==================================================================
  // answer sequencer, one-hot
  typedef enum logic [1:0] {
    GWT_ST_IDLE = 2'b01,
    GWT_ST_ANSWER = 2'b10
  } gwt_state_e;
  // ==================================================================
  // whole register state of the core
  typedef struct packed {
    gwt_state_e st;
    logic [15:0] warn_sp;
    logic warn_en;
    logic w2r;
    logic failsafe;
    logic sounder;
    logic test_due;
    logic alarm;
    logic warn_hit;
    logic fault_s1;
    logic fault_s2;
    logic relay_on;
    logic nv_save;
    logic [7:0] exc;
    logic [15:0] rdata;
  } gwt_state_s;
endpackage

// ==== verilog/gwt_core.sv ====
// Purpose: warning threshold, status flags and relay drive of a gas
//   leak detector, reached by modbus style single-item requests
// Assumes: requests come decoded from the serial front end; gas
//   samples and set points come from logic on mclk
// Notes: one register item per request, answer one cycle later
// ====================================================================
// Summary of operation
// - software warning set point held in ppm
// - enabled warning at or above set point raises flag
// - warning with relay select activates relay
// - failsafe flag selects relay drive polarity
// - warning write above alarm threshold is refused
// - alarm drop below warning clamps and saves
// - alarm raise leaves clamped warning untouched
// - clearing warning enable zeroes and saves
// - alarm flag set at or above threshold
// - relay flag follows relay coil energy
// - sensor fault flag follows missing sensor
// - red lamp lit on alarm or fault
// - green lamp lit unless sensor fault
// - warning flag only live while enabled
// - input flags read-only via code 02
// - output flags read 01, written 05
// - sounder flag mirrors sounder state
// - test flag set after a year running
// - failsafe select resets to standard
// - warning enable resets to off
// - relay on warning only when selected
// - failsafe energises idle, drops on trip
// - zero software alarm selects potentiometer
`include "gwt_map.svh"

module gwt_core
  import gwt_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  // request from the serial front end
  input wire logic req,
  input wire logic [7:0] func,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  output logic ack,
  output logic [7:0] exc,
  output logic [15:0] rdata,
  // measurement and thresholds
  input wire logic gas_valid,
  input wire logic [15:0] gas_ppm,
  input wire logic [15:0] sw_alarm_ppm,
  input wire logic [15:0] pot_alarm_ppm,
  input wire logic sensor_fault_pin,
  input wire logic year_elapsed,
  // field outputs
  output logic relay_drive,
  output logic sounder_on,
  output logic red_lamp,
  output logic green_lamp,
  output logic warn_hit,
  // persistent copy of the warning set point
  output logic nv_save,
  output logic [15:0] nv_value
);

  // ==================================================================
  // helpers
  function automatic logic [15:0] normal_thr(
    input logic [15:0] sw,
    input logic [15:0] pot
  );
    normal_thr = (sw == 16'h0000) ? pot : sw;
  endfunction

  function automatic logic coil_ok(input logic [15:0] v);
    coil_ok = (v == `GWT_COIL_ON) || (v == `GWT_COIL_OFF);
  endfunction

  gwt_state_s cur;
  gwt_state_s next_cur;
  logic [15:0] thr;
  logic activate;
  logic alarm_now;
  logic warn_now;
  logic wr_hold;
  logic wr_coil;
  logic [15:0] sp_cand;

  assign thr = normal_thr(sw_alarm_ppm, pot_alarm_ppm);
  assign alarm_now = gas_ppm >= thr;
  assign warn_now = gas_ppm >= cur.warn_sp;
  assign wr_hold = req && (cur.st == GWT_ST_IDLE) &&
                   (func == `GWT_FC_WR_HOLD) && (addr == `GWT_A_WARN_SP);
  assign wr_coil = req && (cur.st == GWT_ST_IDLE) &&
                   (func == `GWT_FC_WR_COIL) && coil_ok(wdata);

  // ==================================================================
  // next state
  always_comb begin
    next_cur = cur;
    next_cur.nv_save = 1'b0;
    // pin input through two flops before anything reads it
    next_cur.fault_s1 = sensor_fault_pin;
    next_cur.fault_s2 = cur.fault_s1;

    // comparisons refreshed only when a sample lands
    if (gas_valid) begin
      next_cur.alarm = alarm_now;
      next_cur.warn_hit = cur.warn_en && warn_now;
      if (alarm_now && !cur.alarm) begin
        next_cur.sounder = 1'b1;
      end
    end

    // bus sequencer
    case (cur.st)
      GWT_ST_IDLE: begin
        if (req) begin
          next_cur.st = GWT_ST_ANSWER;
          next_cur.exc = `GWT_EX_NONE;
          next_cur.rdata = 16'h0000;
          case (func)
            `GWT_FC_RD_INPUT: begin
              case (addr)
                `GWT_A_ALARM: next_cur.rdata[0] = cur.alarm;
                `GWT_A_RELAY: next_cur.rdata[0] = cur.relay_on;
                `GWT_A_FAULT: next_cur.rdata[0] = cur.fault_s2;
                `GWT_A_RED: next_cur.rdata[0] = cur.alarm | cur.fault_s2;
                `GWT_A_GREEN: next_cur.rdata[0] = ~cur.fault_s2;
                `GWT_A_SPARE_A: next_cur.rdata[0] = 1'b0;
                `GWT_A_SPARE_B: next_cur.rdata[0] = 1'b0;
                `GWT_A_WARN_HIT: next_cur.rdata[0] = cur.warn_hit;
                default: next_cur.exc = `GWT_EX_ADDR;
              endcase
            end
            `GWT_FC_RD_COIL: begin
              case (addr)
                `GWT_A_SOUNDER: next_cur.rdata[0] = cur.sounder;
                `GWT_A_TEST: next_cur.rdata[0] = cur.test_due;
                `GWT_A_FAILSAFE: next_cur.rdata[0] = cur.failsafe;
                `GWT_A_WARN_EN: next_cur.rdata[0] = cur.warn_en;
                `GWT_A_W2R: next_cur.rdata[0] = cur.w2r;
                default: next_cur.exc = `GWT_EX_ADDR;
              endcase
            end
            `GWT_FC_RD_HOLD: begin
              if (addr == `GWT_A_WARN_SP) begin
                next_cur.rdata = cur.warn_sp;
              end else begin
                next_cur.exc = `GWT_EX_ADDR;
              end
            end
            `GWT_FC_WR_COIL: begin
              next_cur.rdata = wdata;
              if (!coil_ok(wdata)) begin
                next_cur.exc = `GWT_EX_VALUE;
              end else begin
                case (addr)
                  `GWT_A_SOUNDER: begin
                    // a sounding onset in this cycle beats a mute
                    next_cur.sounder = wdata[8] |
                      (gas_valid && alarm_now && !cur.alarm);
                  end
                  `GWT_A_TEST: next_cur.test_due = wdata[8] | year_elapsed;
                  `GWT_A_FAILSAFE: next_cur.failsafe = wdata[8];
                  `GWT_A_WARN_EN: next_cur.warn_en = wdata[8];
                  `GWT_A_W2R: next_cur.w2r = wdata[8];
                  default: next_cur.exc = `GWT_EX_ADDR;
                endcase
              end
            end
            `GWT_FC_WR_HOLD: begin
              next_cur.rdata = wdata;
              if (addr != `GWT_A_WARN_SP) begin
                next_cur.exc = `GWT_EX_ADDR;
              end else if (wdata > thr) begin
                next_cur.exc = `GWT_EX_VALUE;
              end
            end
            default: next_cur.exc = `GWT_EX_FUNC;
          endcase
        end
      end
      GWT_ST_ANSWER: begin
        next_cur.st = GWT_ST_IDLE;
      end
      default: begin
        next_cur.st = GWT_ST_IDLE;
      end
    endcase

    if (year_elapsed) begin
      next_cur.test_due = 1'b1;
    end

    // warning set point: write, disable, then clamp
    sp_cand = cur.warn_sp;
    if (wr_hold && (wdata <= thr)) begin
      sp_cand = wdata;
    end
    if (!next_cur.warn_en) begin
      sp_cand = 16'h0000;
      next_cur.warn_hit = 1'b0;
    end
    if (thr < sp_cand) begin
      // never raised back when the alarm level later climbs
      sp_cand = thr;
    end
    next_cur.warn_sp = sp_cand;
    next_cur.nv_save = (sp_cand != cur.warn_sp) || wr_hold &&
                       (wdata <= thr);

    // relay: any trip inverts the resting state
    next_cur.relay_on = activate ^ cur.failsafe;
  end

  assign activate = cur.fault_s2 | cur.alarm |
                    (cur.warn_hit & cur.w2r);

  // ==================================================================
  // state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      cur.st <= GWT_ST_IDLE;
      cur.warn_sp <= `GWT_RST_WARN_SP;
      cur.warn_en <= `GWT_RST_FLAG;
      cur.w2r <= `GWT_RST_FLAG;
      cur.failsafe <= `GWT_RST_FLAG;
      cur.sounder <= `GWT_RST_FLAG;
      cur.test_due <= `GWT_RST_FLAG;
      cur.alarm <= `GWT_RST_FLAG;
      cur.warn_hit <= `GWT_RST_FLAG;
      cur.fault_s1 <= `GWT_RST_FLAG;
      cur.fault_s2 <= `GWT_RST_FLAG;
      cur.relay_on <= `GWT_RST_FLAG;
      cur.nv_save <= `GWT_RST_FLAG;
      cur.exc <= `GWT_EX_NONE;
      cur.rdata <= 16'h0000;
    end else begin
      cur <= next_cur;
    end
  end

  // ==================================================================
  // outputs
  assign ack = (cur.st == GWT_ST_ANSWER);
  assign exc = cur.exc;
  assign rdata = cur.rdata;
  assign relay_drive = cur.relay_on;
  assign sounder_on = cur.sounder;
  assign red_lamp = cur.alarm | cur.fault_s2;
  assign green_lamp = ~cur.fault_s2;
  assign warn_hit = cur.warn_hit;
  assign nv_save = cur.nv_save;
  assign nv_value = cur.warn_sp;

  // ==================================================================
  // checks
  AST_WARN_LE_THR: assert property (
    @(posedge mclk) disable iff (rst)
    ($stable(thr) && $past(cur.warn_sp) <= $past(thr)) |->
      cur.warn_sp <= thr)
    else $error("warning set point above alarm threshold");

  AST_REFUSE_HIGH: assert property (
    @(posedge mclk) disable iff (rst)
    (wr_hold && wdata > thr && cur.warn_en && thr >= cur.warn_sp) |=>
      (cur.warn_sp == $past(cur.warn_sp) && exc == `GWT_EX_VALUE && ack))
    else $error("high warning write not refused");

  AST_CLAMP: assert property (
    @(posedge mclk) disable iff (rst)
    (!wr_hold && !wr_coil && cur.warn_en && thr < cur.warn_sp) |=>
      (cur.warn_sp == $past(thr) && nv_save))
    else $error("warning set point not clamped and saved");

  AST_NO_RAISE: assert property (
    @(posedge mclk) disable iff (rst)
    (!wr_hold && thr > $past(thr)) |=> cur.warn_sp <= $past(cur.warn_sp))
    else $error("warning set point raised without a write");

  AST_DISABLE_ZERO: assert property (
    @(posedge mclk) disable iff (rst)
    (wr_coil && addr == `GWT_A_WARN_EN && wdata == `GWT_COIL_OFF) |=>
      (cur.warn_sp == 16'h0000 && !warn_hit))
    else $error("disable did not zero the warning set point");

  AST_ALARM_SAMPLE: assert property (
    @(posedge mclk) disable iff (rst)
    gas_valid |=> cur.alarm == $past(gas_ppm >= thr))
    else $error("alarm flag wrong after sample");

  AST_WARN_ONLY_EN: assert property (
    @(posedge mclk) disable iff (rst)
    warn_hit |-> cur.warn_en)
    else $error("warning flag set while disabled");

  AST_RELAY_POL: assert property (
    @(posedge mclk) disable iff (rst)
    ##1 relay_drive == ($past(activate) ^ $past(cur.failsafe)))
    else $error("relay drive polarity wrong");

  AST_RESET_POL: assert property (
    @(posedge mclk)
    $fell(rst) |-> (!cur.failsafe && !cur.warn_en && !cur.w2r))
    else $error("control flags not cleared by reset");

  AST_READONLY_IN: assert property (
    @(posedge mclk) disable iff (rst)
    (req && !ack && func == `GWT_FC_WR_COIL && addr >= `GWT_A_ALARM &&
     addr <= `GWT_A_WARN_HIT && coil_ok(wdata)) |=>
      (ack && exc == `GWT_EX_ADDR))
    else $error("input flag accepted a write");

  AST_TEST_SET: assert property (
    @(posedge mclk) disable iff (rst)
    year_elapsed |=> cur.test_due)
    else $error("test flag not set after a year");

  AST_RED_LAMP: assert property (
    @(posedge mclk) disable iff (rst)
    (gas_valid && gas_ppm >= thr) |=> red_lamp)
    else $error("red lamp not lit on alarm sample");

  AST_WARN_SET: assert property (
    @(posedge mclk) disable iff (rst)
    (gas_valid && cur.warn_en && gas_ppm >= cur.warn_sp && !wr_coil) |=>
      warn_hit)
    else $error("warning flag not raised above set point");

  AST_W2R_RELAY: assert property (
    @(posedge mclk) disable iff (rst)
    (cur.warn_hit && cur.w2r) |=> relay_drive == !$past(cur.failsafe))
    else $error("warning did not move the relay");

  AST_NO_W2R: assert property (
    @(posedge mclk) disable iff (rst)
    (!cur.w2r && !cur.alarm && !cur.fault_s2) |=>
      relay_drive == $past(cur.failsafe))
    else $error("relay moved without alarm or fault");

  AST_SOUNDER_ONSET: assert property (
    @(posedge mclk) disable iff (rst)
    (gas_valid && gas_ppm >= thr && !cur.alarm) |=> sounder_on)
    else $error("sounder not started on alarm onset");

  AST_FAULT_SYNC: assert property (
    @(posedge mclk) disable iff (rst)
    sensor_fault_pin |-> ##2 cur.fault_s2)
    else $error("sensor fault not seen after two edges");

  AST_ACK_PULSE: assert property (
    @(posedge mclk) disable iff (rst)
    ack |=> !ack)
    else $error("answer strobe longer than one cycle");

endmodule
